// ===== rtl/pgi_chan.sv
// One power-good output: fault register, behaviour select and assert delay
`timescale 1ns/1ps
`default_nettype none
`include "pgi_regs.svh"

module pgi_chan #(
	parameter logic [17:0] RISE_CYC = 18'(`PGI_RISE_CYC)
) (
	input wire logic clk,
	input wire logic rst_n,
	pgi_chan_if.chan ch
);
	import pgi_pkg::*;

	pgi_state_t state_ff;
	pgi_state_t nxt_state;
	pgi_src_t fault_ff;
	logic [17:0] dly_cnt_ff;
	pgi_src_t sel;
	logic mode;
	logic gated_ok;
	logic cont_ok;
	logic raw_ok;

	// ****************************************
	// Health terms
	// ****************************************
	assign sel = ch.cfg[`PGI_CTRL_SEL +: 7];
	assign mode = ch.cfg[`PGI_CTRL_MODE];
	// Gated: any latched fault keeps the output down until cleared
	assign gated_ok = ~|fault_ff & ~|(ch.ev & sel) & ~ch.crit;
	// Continuous: live rail status, pending input interrupts, optional fault hold
	assign cont_ok = ~|(sel[2:0] & ch.rail_nok) & ~|(sel[6:3] & ch.pend[6:3]) & ~ch.crit
		& ~(ch.cfg[`PGI_CTRL_HOLD] & |fault_ff);
	assign raw_ok = mode ? cont_ok : gated_ok;

	// Fault bits latch; a new event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			fault_ff <= 7'h00;
		else if (ch.loaded)
			fault_ff <= (fault_ff & ~ch.clr) | (ch.ev & sel);
	end

	// Output state sequence
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			PGI_ST_LOAD:
				if (ch.loaded)
					nxt_state = PGI_ST_ACTIVE;
			PGI_ST_ACTIVE:
				if (!raw_ok)
					nxt_state = PGI_ST_FAULT;
			PGI_ST_FAULT:
				if (raw_ok)
					nxt_state = ch.cfg[`PGI_CTRL_RDLY] ? PGI_ST_WAIT : PGI_ST_ACTIVE;
			PGI_ST_WAIT:
				if (!raw_ok)
					nxt_state = PGI_ST_FAULT;
				else if (dly_cnt_ff == RISE_CYC - 18'h00001)
					nxt_state = PGI_ST_ACTIVE;
			default:
				nxt_state = PGI_ST_LOAD;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_ff <= PGI_ST_LOAD;
		else
			state_ff <= nxt_state;
	end

	// Assert delay counter runs only while waiting
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dly_cnt_ff <= 18'h00000;
		else if (state_ff == PGI_ST_WAIT && raw_ok)
			dly_cnt_ff <= dly_cnt_ff + 18'h00001;
		else
			dly_cnt_ff <= 18'h00000;
	end

	assign ch.fault = fault_ff;
	assign ch.active = (state_ff == PGI_ST_ACTIVE);

endmodule

`default_nettype wire

// ===== rtl/pgi_chan_if.sv
// Signals between the shared supervision logic and one power-good output
`timescale 1ns/1ps
`default_nettype none

interface pgi_chan_if;
	import pgi_pkg::*;
	pgi_word_t cfg;
	pgi_src_t ev;
	pgi_src_t pend;
	logic [2:0] rail_nok;
	logic crit;
	pgi_src_t clr;
	logic loaded;
	pgi_src_t fault;
	logic active;

	modport main (output cfg, ev, pend, rail_nok, crit, clr, loaded, input fault, active);
	modport chan (input cfg, ev, pend, rail_nok, crit, clr, loaded, output fault, active);
endinterface

`default_nettype wire

// ===== rtl/pgi_pkg.sv
// Types shared by the power-good block
package pgi_pkg;

	// Register data word and source vector
	typedef logic [15:0] pgi_word_t;
	typedef logic [7:0] pgi_addr_t;
	typedef logic [6:0] pgi_src_t;

	// Output state, Gray coded along load, active, fault, wait
	typedef enum logic [1:0]
	{
		PGI_ST_LOAD = 2'h0,
		PGI_ST_ACTIVE = 2'h1,
		PGI_ST_FAULT = 2'h3,
		PGI_ST_WAIT = 2'h2
	} pgi_state_t;

endpackage

// ===== rtl/pgi_regs.svh
// Register offsets, field positions, reset values and timing counts of the power-good block
`ifndef PGI_REGS_SVH
`define PGI_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PGI_OFS_CTRL_FIRST 8'h00
`define PGI_OFS_CTRL_SECOND 8'h04
`define PGI_OFS_SUPV 8'h08
`define PGI_OFS_FAULT_FIRST 8'h0C
`define PGI_OFS_FAULT_SECOND 8'h10
`define PGI_OFS_INT_TOP 8'h14
`define PGI_OFS_INT_CONV 8'h18
`define PGI_OFS_DIAGNOSTIC_INTERRUPT_REG 8'h1C
`define PGI_OFS_STATUS 8'h20

// ****************************************
// Output control fields
// ****************************************
`define PGI_CTRL_MODE 0
`define PGI_CTRL_HOLD 1
`define PGI_CTRL_RDLY 2
`define PGI_CTRL_POL 3
`define PGI_CTRL_OD 4
`define PGI_CTRL_SEL 5
`define PGI_CTRL_RST 16'h0FE8

// ****************************************
// Supervision enable and top interrupt fields
// ****************************************
`define PGI_SUPV_RST 6'h3F
// Input filter rest pattern: the three input monitors start as valid
`define PGI_SYNC_RST 16'h0E00
`define PGI_TOP_OVP 0
`define PGI_TOP_TSD 1
`define PGI_TOP_TWARN 2

// ****************************************
// Timing
// ****************************************
`define PGI_CLK_MHZ 20
`define PGI_BLANK_US 800
`define PGI_BLANK_CYC (`PGI_BLANK_US * `PGI_CLK_MHZ)
`define PGI_RISE_MS 11
`define PGI_RISE_CYC (`PGI_RISE_MS * 1000 * `PGI_CLK_MHZ)

`endif

// ===== rtl/pgi_top.sv
// Power-good indicator logic: supervision, interrupt registers and two power-good outputs
//
// How it works
// - Behaviour bit 0 selects gated behaviour, flagging only abnormal conditions.
// - Behaviour bit 1 selects continuous behaviour, tracking all requested voltages.
// - Each output goes asserted when configuration load finishes, in either behaviour.
// - Gated behaviour ignores a rail for 800 us after its enable.
// - Gated: rail invalid, or still invalid after 800 us, drops the output.
// - Invalid analog supply or either external monitor drops the output.
// - Each rail, input monitor or thermal warning fault sets its bit in that output's fault register.
// - Gated: output stays inactive until the host clears the fault.
// - Overvoltage and thermal faults clear by write-one to top interrupt register.
// - Converter, monitor and supply faults clear by write-one to their registers.
// - Continuous: output drops as soon as a rail is enabled, no blanking.
// - Continuous: output follows current regulation status without delay.
// - Continuous: invalid rail drops the output; outside its 800 us window it also sets its fault bit.
// - Fault bits latch until the host writes one to each.
// - Continuous: pending supply, monitor and thermal interrupts also drop it.
// - Continuous: output stays inactive while a rail ramps to a new voltage.
// - Continuous: output returns when rails are valid, unless fault hold applies.
// - Fault hold set keeps the output inactive while any fault bit remains.
// - A disabled rail is masked from both output and interrupts.
// - Assert delay bit set delays assertion by 11 ms after all valid.
// - Each output has its own polarity and push-pull or open-drain choice.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pgi_regs.svh"

module pgi_top #(
	parameter logic [17:0] BLANK_CYC = 18'(`PGI_BLANK_CYC),
	parameter logic [17:0] RISE_CYC = 18'(`PGI_RISE_CYC)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire pgi_pkg::pgi_addr_t addr,
	input wire pgi_pkg::pgi_word_t wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output pgi_pkg::pgi_word_t rdata,
	input wire logic [2:0] rail_enable,
	input wire logic [2:0] rail_valid,
	input wire logic [2:0] rail_ramp,
	input wire logic analog_supply_input_ok,
	input wire logic ext_monitor_input_a_ok,
	input wire logic ext_monitor_input_b_ok,
	input wire logic overvoltage_det,
	input wire logic thermal_shutdown_det,
	input wire logic thermal_warning_det,
	input wire logic otp_load_done,
	output logic power_good_out_first,
	output logic power_good_out_first_oe_n,
	output logic power_good_out_second,
	output logic power_good_out_second_oe_n
);
	import pgi_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic [15:0] raw_in;
	logic [15:0] sync1_ff;
	logic [15:0] sync2_ff;
	logic [15:0] sync3_ff;
	logic [15:0] filt_ff;
	logic [2:0] en_f;
	logic [2:0] valid_f;
	logic [2:0] ramp_f;
	logic [2:0] in_ok_f;
	logic ovp_f;
	logic tsd_f;
	logic twarn_f;
	logic loaded_f;
	pgi_word_t ctrl_first_ff;
	pgi_word_t ctrl_second_ff;
	logic [5:0] supv_ff;
	logic [2:0] int_top_ff;
	logic [2:0] int_conv_ff;
	logic [2:0] diagnostic_interrupt_reg_ff;
	logic [2:0] on_d_ff;
	logic [2:0] ramp_d_ff;
	logic [17:0] blank_cnt_ff [3];
	logic [2:0] rail_on;
	logic [2:0] blank;
	logic [2:0] rail_bad;
	logic [2:0] in_bad;
	pgi_src_t ev;
	pgi_src_t pend;
	pgi_src_t map_clr;
	logic wr_ctrl_first;
	logic wr_ctrl_second;
	logic wr_supv;
	logic wr_fault_first;
	logic wr_fault_second;
	logic wr_top;
	logic wr_conv;
	logic wr_diag;
	pgi_word_t rd_mux;
	pgi_word_t rdata_ff;
	logic level_first;
	logic level_second;

	pgi_chan_if ch_first ();
	pgi_chan_if ch_second ();

	// ****************************************
	// Input synchronisers
	// ****************************************
	assign raw_in = {otp_load_done, thermal_warning_det, thermal_shutdown_det, overvoltage_det,
		ext_monitor_input_b_ok, ext_monitor_input_a_ok, analog_supply_input_ok,
		rail_ramp, rail_valid, rail_enable};

	// Three-stage chain; a bit changes once stages two and three agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_ff <= `PGI_SYNC_RST;
			sync2_ff <= `PGI_SYNC_RST;
			sync3_ff <= `PGI_SYNC_RST;
			filt_ff <= `PGI_SYNC_RST; // No false input faults after reset
		end
		else
		begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			filt_ff <= (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff | sync3_ff));
		end
	end

	// Filtered fields
	assign en_f = filt_ff[2:0];
	assign valid_f = filt_ff[5:3];
	assign ramp_f = filt_ff[8:6];
	assign in_ok_f = filt_ff[11:9];
	assign ovp_f = filt_ff[12];
	assign tsd_f = filt_ff[13];
	assign twarn_f = filt_ff[14];
	assign loaded_f = filt_ff[15];

	// ****************************************
	// Register write decode
	// ****************************************
	assign wr_ctrl_first = wr_en && addr == `PGI_OFS_CTRL_FIRST;
	assign wr_ctrl_second = wr_en && addr == `PGI_OFS_CTRL_SECOND;
	assign wr_supv = wr_en && addr == `PGI_OFS_SUPV;
	assign wr_fault_first = wr_en && addr == `PGI_OFS_FAULT_FIRST;
	assign wr_fault_second = wr_en && addr == `PGI_OFS_FAULT_SECOND;
	assign wr_top = wr_en && addr == `PGI_OFS_INT_TOP;
	assign wr_conv = wr_en && addr == `PGI_OFS_INT_CONV;
	assign wr_diag = wr_en && addr == `PGI_OFS_DIAGNOSTIC_INTERRUPT_REG;

	// Output control and supervision enable registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_first_ff <= `PGI_CTRL_RST;
			ctrl_second_ff <= `PGI_CTRL_RST;
			supv_ff <= `PGI_SUPV_RST;
		end
		else
		begin
			if (wr_ctrl_first)
				ctrl_first_ff <= wdata & 16'h0FFF;
			if (wr_ctrl_second)
				ctrl_second_ff <= wdata & 16'h0FFF;
			if (wr_supv)
				supv_ff <= wdata[5:0];
		end
	end

	// ****************************************
	// Per-rail blanking window
	// ****************************************
	// A disabled or unsupervised rail is masked everywhere
	assign rail_on = en_f & supv_ff[2:0];

	// Edge memory for enable and voltage-change requests
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			on_d_ff <= 3'h0;
			ramp_d_ff <= 3'h0;
		end
		else
		begin
			on_d_ff <= rail_on;
			ramp_d_ff <= ramp_f;
		end
	end

	// Counter restarts on each enable or voltage change and runs down to zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 3; i++)
				blank_cnt_ff[i] <= 18'h00000;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (!rail_on[i])
					blank_cnt_ff[i] <= 18'h00000;
				else if (!on_d_ff[i] || (ramp_f[i] && !ramp_d_ff[i]))
					blank_cnt_ff[i] <= BLANK_CYC;
				else if (blank_cnt_ff[i] != 18'h00000)
					blank_cnt_ff[i] <= blank_cnt_ff[i] - 18'h00001;
			end
		end
	end

	// Window open while counting, including the starting cycle
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			blank[i] = rail_on[i] && (blank_cnt_ff[i] != 18'h00000 || !on_d_ff[i]
				|| (ramp_f[i] && !ramp_d_ff[i]));
	end

	// ****************************************
	// Fault events
	// ****************************************
	// Rail invalid outside its window, input monitors invalid while supervised
	assign rail_bad = rail_on & ~blank & ~valid_f;
	assign in_bad = supv_ff[5:3] & ~in_ok_f;
	assign ev = {twarn_f, in_bad, rail_bad};

	// Top interrupts; a new event wins over a write-one clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			int_top_ff <= 3'h0;
		else
			int_top_ff <= (int_top_ff & ~(wr_top ? wdata[2:0] : 3'h0))
				| {twarn_f, tsd_f, ovp_f};
	end

	// Converter and diagnostic interrupts
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			int_conv_ff <= 3'h0;
			diagnostic_interrupt_reg_ff <= 3'h0;
		end
		else
		begin
			int_conv_ff <= (int_conv_ff & ~(wr_conv ? wdata[2:0] : 3'h0)) | rail_bad;
			diagnostic_interrupt_reg_ff <= (diagnostic_interrupt_reg_ff & ~(wr_diag ? wdata[2:0] : 3'h0)) | in_bad;
		end
	end

	// Interrupt clears also release the matching fault bits
	assign map_clr = {wr_top & wdata[`PGI_TOP_TWARN], wr_diag ? wdata[2:0] : 3'h0,
		wr_conv ? wdata[2:0] : 3'h0};
	assign pend = {int_top_ff[`PGI_TOP_TWARN], diagnostic_interrupt_reg_ff, int_conv_ff};

	// ****************************************
	// Power-good channels
	// ****************************************
	// Shared supervision terms to the first output
	assign ch_first.cfg = ctrl_first_ff;
	assign ch_first.ev = ev;
	assign ch_first.pend = pend;
	assign ch_first.rail_nok = rail_on & (~valid_f | ramp_f);
	assign ch_first.crit = int_top_ff[`PGI_TOP_OVP] | int_top_ff[`PGI_TOP_TSD];
	assign ch_first.clr = map_clr | (wr_fault_first ? wdata[6:0] : 7'h00);
	assign ch_first.loaded = loaded_f;

	// Shared supervision terms to the second output
	assign ch_second.cfg = ctrl_second_ff;
	assign ch_second.ev = ev;
	assign ch_second.pend = pend;
	assign ch_second.rail_nok = rail_on & (~valid_f | ramp_f);
	assign ch_second.crit = int_top_ff[`PGI_TOP_OVP] | int_top_ff[`PGI_TOP_TSD];
	assign ch_second.clr = map_clr | (wr_fault_second ? wdata[6:0] : 7'h00);
	assign ch_second.loaded = loaded_f;

	// Independent output instances
	pgi_chan #(
		.RISE_CYC(RISE_CYC)
	) u_first (
		.clk(clk),
		.rst_n(rst_n),
		.ch(ch_first)
	);

	pgi_chan #(
		.RISE_CYC(RISE_CYC)
	) u_second (
		.clk(clk),
		.rst_n(rst_n),
		.ch(ch_second)
	);

	// ****************************************
	// Output pins
	// ****************************************
	// Pin level carries the polarity; open-drain releases the high level
	assign level_first = ch_first.active ~^ ctrl_first_ff[`PGI_CTRL_POL];
	assign level_second = ch_second.active ~^ ctrl_second_ff[`PGI_CTRL_POL];
	assign power_good_out_first = ctrl_first_ff[`PGI_CTRL_OD] ? 1'b0 : level_first;
	assign power_good_out_first_oe_n = ctrl_first_ff[`PGI_CTRL_OD] & level_first;
	assign power_good_out_second = ctrl_second_ff[`PGI_CTRL_OD] ? 1'b0 : level_second;
	assign power_good_out_second_oe_n = ctrl_second_ff[`PGI_CTRL_OD] & level_second;

	// ****************************************
	// Register read
	// ****************************************
	// Read mux; unmapped offsets read zero
	always_comb
	begin
		case (addr)
			`PGI_OFS_CTRL_FIRST: rd_mux = ctrl_first_ff;
			`PGI_OFS_CTRL_SECOND: rd_mux = ctrl_second_ff;
			`PGI_OFS_SUPV: rd_mux = {10'h000, supv_ff};
			`PGI_OFS_FAULT_FIRST: rd_mux = {9'h000, ch_first.fault};
			`PGI_OFS_FAULT_SECOND: rd_mux = {9'h000, ch_second.fault};
			`PGI_OFS_INT_TOP: rd_mux = {13'h0000, int_top_ff};
			`PGI_OFS_INT_CONV: rd_mux = {13'h0000, int_conv_ff};
			`PGI_OFS_DIAGNOSTIC_INTERRUPT_REG: rd_mux = {13'h0000, diagnostic_interrupt_reg_ff};
			`PGI_OFS_STATUS: rd_mux = {5'h00, ch_second.active, ch_first.active,
				blank, valid_f, rail_on};
			default: rd_mux = 16'h0000;
		endcase
	end

	// Read data stand for one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= 16'h0000;
		else
			rdata_ff <= rd_en ? rd_mux : 16'h0000;
	end

	assign rdata = rdata_ff;

endmodule

`default_nettype wire

// ===== tb/pgi_host_model.sv
// Host processor reset input fed by one power-good pin
`timescale 1ns/1ps
`default_nettype none
module pgi_host_model (
	input wire logic pg_val,
	input wire logic pg_oe_n,
	input wire logic pg_pol,
	output logic pin_level,
	output logic processor_power_on_reset_n
);
	// Board pull-up sets the level of a released open-drain pin
	assign pin_level = pg_oe_n ? 1'b1 : pg_val;
	// Processor leaves reset only while the indication is active
	assign processor_power_on_reset_n = (pin_level == pg_pol);
endmodule
`default_nettype wire

// ===== tb/pgi_top_props.sv
// Port-level assertions of the power-good block
`timescale 1ns/1ps
`default_nettype none
module pgi_top_props #(
	parameter logic [17:0] BLANK_CYC = 18'h00014,
	parameter logic [17:0] RISE_CYC = 18'h0001E
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire pgi_pkg::pgi_addr_t addr,
	input wire pgi_pkg::pgi_word_t wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire pgi_pkg::pgi_word_t rdata,
	input wire logic [2:0] rail_enable,
	input wire logic [2:0] rail_valid,
	input wire logic [2:0] rail_ramp,
	input wire logic analog_supply_input_ok,
	input wire logic overvoltage_det,
	input wire logic thermal_shutdown_det,
	input wire logic power_good_out_first,
	input wire logic power_good_out_first_oe_n,
	input wire logic power_good_out_second,
	input wire logic power_good_out_second_oe_n
);
	import pgi_pkg::*;
	pgi_word_t ctl1_ff;
	logic pol2_ff;
	logic [5:0] supv_ff;
	logic act1;
	logic act2;
	// Shadow of the settings the host wrote
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl1_ff <= 16'h0FE8;
			pol2_ff <= 1'b1;
			supv_ff <= 6'h3F;
		end
		else if (wr_en)
		begin
			if (addr == 8'h00)
				ctl1_ff <= wdata & 16'h0FFF;
			if (addr == 8'h04)
				pol2_ff <= wdata[3];
			if (addr == 8'h08)
				supv_ff <= wdata[5:0];
		end
	end
	// Active state of each pin, open-drain release reads high
	assign act1 = ((power_good_out_first_oe_n ? 1'b1 : power_good_out_first) == ctl1_ff[3]);
	assign act2 = ((power_good_out_second_oe_n ? 1'b1 : power_good_out_second) == pol2_ff);
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	chk_rdata_idle: assert property (!rd_en |=> rdata == 16'h0000)
		else $error("read data not zero outside a read answer");
	chk_unmapped_zero: assert property ((rd_en && (addr[1:0] != 2'h0 || addr > 8'h20))
		|=> rdata == 16'h0000)
		else $error("unmapped read returned data");
	chk_ctrl_readback: assert property ((rd_en && addr == 8'h00) |=> rdata == $past(ctl1_ff))
		else $error("first control word readback wrong");
	chk_low_driven: assert property (ctl1_ff[4] |-> !power_good_out_first)
		else $error("open-drain first pin drove a high level");
	chk_push_pull: assert property (!ctl1_ff[4] |-> !power_good_out_first_oe_n)
		else $error("push-pull pin not driven");
	chk_ovp_forces: assert property (overvoltage_det[*8] |-> (!act1 && !act2))
		else $error("overvoltage left an output active");
	chk_tsd_second: assert property (thermal_shutdown_det[*8] |-> !act2)
		else $error("thermal shutdown left second output active");
	chk_supply_drop: assert property ((!analog_supply_input_ok && ctl1_ff[8] && supv_ff[3])[*8]
		|-> !act1)
		else $error("invalid supply left first output active");
	chk_cont_rail: assert property ((ctl1_ff[0] && ctl1_ff[5] && supv_ff[0] && rail_enable[0]
		&& (!rail_valid[0] || rail_ramp[0]))[*8] |-> !act1)
		else $error("continuous output active with rail not good");
endmodule
bind pgi_top pgi_top_props #(.BLANK_CYC(BLANK_CYC), .RISE_CYC(RISE_CYC)) u_props (
	.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
	.rdata(rdata), .rail_enable(rail_enable), .rail_valid(rail_valid), .rail_ramp(rail_ramp),
	.analog_supply_input_ok(analog_supply_input_ok), .overvoltage_det(overvoltage_det),
	.thermal_shutdown_det(thermal_shutdown_det), .power_good_out_first(power_good_out_first),
	.power_good_out_first_oe_n(power_good_out_first_oe_n),
	.power_good_out_second(power_good_out_second),
	.power_good_out_second_oe_n(power_good_out_second_oe_n)
);
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the power-good block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pgi_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	pgi_addr_t addr = 8'h00;
	pgi_word_t wdata = 16'h0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	pgi_word_t rdata;
	logic [2:0] ren = 3'h0;
	logic [2:0] rval = 3'h0;
	logic [2:0] rramp = 3'h0;
	logic [2:0] in_ok = 3'h7;
	logic [2:0] det = 3'h0;
	logic otp_done = 1'b0;
	logic pol1 = 1'b1;
	logic pg1, pg1_oe_n, pg2, pg2_oe_n, run1, run2;
	int mismatches = 0;
	int total_checks = 0;
	// Clock at 20 MHz
	always #25 clk = ~clk;
	pgi_top #(.BLANK_CYC(18'h00014), .RISE_CYC(18'h0001E)) dut (
		.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .rail_enable(ren), .rail_valid(rval), .rail_ramp(rramp),
		.analog_supply_input_ok(in_ok[0]), .ext_monitor_input_a_ok(in_ok[1]),
		.ext_monitor_input_b_ok(in_ok[2]), .overvoltage_det(det[0]),
		.thermal_shutdown_det(det[1]), .thermal_warning_det(det[2]), .otp_load_done(otp_done),
		.power_good_out_first(pg1), .power_good_out_first_oe_n(pg1_oe_n),
		.power_good_out_second(pg2), .power_good_out_second_oe_n(pg2_oe_n));
	pgi_host_model h1 (.pg_val(pg1), .pg_oe_n(pg1_oe_n), .pg_pol(pol1), .pin_level(),
		.processor_power_on_reset_n(run1));
	pgi_host_model h2 (.pg_val(pg2), .pg_oe_n(pg2_oe_n), .pg_pol(1'b1), .pin_level(),
		.processor_power_on_reset_n(run2));
	// ****************************************
	// Bus and compare helpers
	// ****************************************
	task automatic chk(input string n, input pgi_word_t e, input pgi_word_t g);
		total_checks++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	task automatic wr(input pgi_addr_t a, input pgi_word_t v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input pgi_addr_t a, input pgi_word_t e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		chk("register", e, rdata);
	endtask
	// Wait out input filtering, then judge the first output
	task automatic pg(input logic e);
		repeat (8) @(negedge clk);
		chk("power_good_first", {15'h0000, e}, {15'h0000, run1});
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		@(negedge clk);
		chk("pin_first", 16'h0000, {14'h0000, pg1, pg1_oe_n});
		rd(8'h00, 16'h0FE8);
		rd(8'h04, 16'h0FE8);
		rd(8'h08, 16'h003F);
		rd(8'h0C, 16'h0000);
		rd(8'h24, 16'h0000);
		wr(8'h20, 16'hFFFF);
		rd(8'h20, 16'h0000);
		@(posedge clk);
		otp_done <= 1'b1;
		pg(1'b1);
		chk("power_good_second", 16'h0001, {15'h0000, run2});
	endtask
	task automatic t_gated;
		@(posedge clk);
		ren <= 3'h1;
		repeat (12) @(negedge clk);
		chk("window_first", 16'h0001, {15'h0000, run1});
		repeat (12) @(posedge clk);
		pg(1'b0);
		rd(8'h0C, 16'h0001);
		rd(8'h18, 16'h0001);
		@(posedge clk);
		rval <= 3'h1;
		pg(1'b0);
		wr(8'h18, 16'h0001);
		pg(1'b1);
		rd(8'h0C, 16'h0000);
		@(posedge clk);
		ren <= 3'h3;
		repeat (10) @(posedge clk);
		rval <= 3'h3;
		pg(1'b1);
		repeat (20) @(posedge clk);
		rd(8'h0C, 16'h0000);
		@(posedge clk);
		ren <= 3'h1;
		rval <= 3'h1;
	endtask
	task automatic t_cont;
		wr(8'h00, 16'h0FE9);
		pg(1'b1);
		@(posedge clk);
		rramp <= 3'h1;
		pg(1'b0);
		@(posedge clk);
		rramp <= 3'h0;
		pg(1'b1);
		repeat (16) @(posedge clk);
		rval <= 3'h0;
		pg(1'b0);
		rd(8'h0C, 16'h0001);
		@(posedge clk);
		rval <= 3'h1;
		pg(1'b1);
		wr(8'h00, 16'h0FEB);
		pg(1'b0);
		wr(8'h0C, 16'h0001);
		pg(1'b1);
		wr(8'h00, 16'h0FE9);
		@(posedge clk);
		ren <= 3'h2;
		rval <= 3'h0;
		pg(1'b0);
		@(posedge clk);
		rval <= 3'h2;
		pg(1'b1);
	endtask
	task automatic t_inputs;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			in_ok[i] <= 1'b0;
			pg(1'b0);
			rd(8'h1C, 16'h0001 << i);
			@(posedge clk);
			in_ok[i] <= 1'b1;
			pg(1'b0);
			wr(8'h1C, 16'h0001 << i);
			pg(1'b1);
		end
	endtask
	task automatic t_det;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			det[i] <= 1'b1;
			pg(1'b0);
			@(posedge clk);
			det[i] <= 1'b0;
			pg(1'b0);
			rd(8'h14, 16'h0001 << i);
			wr(8'h14, 16'h0001 << i);
			pg(1'b1);
		end
	endtask
	task automatic t_pin;
		wr(8'h00, 16'h0FE5);
		pol1 <= 1'b0;
		pg(1'b1);
		chk("pin_first", 16'h0000, {14'h0000, pg1, pg1_oe_n});
		@(posedge clk);
		in_ok[0] <= 1'b0;
		pg(1'b0);
		@(posedge clk);
		in_ok[0] <= 1'b1;
		pg(1'b0);
		wr(8'h1C, 16'h0001);
		repeat (20) @(negedge clk);
		chk("delayed_first", 16'h0000, {15'h0000, run1});
		repeat (10) @(posedge clk);
		pg(1'b1);
		wr(8'h00, 16'h0FF1);
		@(posedge clk);
		in_ok[0] <= 1'b0;
		pg(1'b0);
		chk("oe_first", 16'h0001, {15'h0000, pg1_oe_n});
		@(posedge clk);
		in_ok[0] <= 1'b1;
		pg(1'b0);
		wr(8'h1C, 16'h0001);
		pg(1'b1);
		chk("oe_first", 16'h0000, {15'h0000, pg1_oe_n});
	endtask
	// Verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_gated;
		t_cont;
		t_inputs;
		t_det;
		t_pin;
		stop_test;
	end
	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (4000) @(posedge clk);
		mismatches++;
		stop_test;
	end
endmodule
`default_nettype wire
